//--- tb/trgctl_switch_model.sv
// switch contact model driving the trigger input
`timescale 1ns/10ps
module trgctl_switch_model
#(
  parameter int HOLD_CYCLES = 40
)
(
  input  wire logic sys_clk,
  output logic      trig_in
);
  initial trig_in = 1'b0;

  // each level is kept for HOLD_CYCLES cycles, well beyond the 6-cycle shortened filter
  task automatic drive(input logic lvl);
    @(posedge sys_clk);
    trig_in <= lvl;
    repeat (HOLD_CYCLES) @(posedge sys_clk);
  endtask : drive

  // one-cycle contact bounce, far below the filter time
  task automatic bounce();
    @(posedge sys_clk);
    trig_in <= ~trig_in;
    @(posedge sys_clk);
    trig_in <= ~trig_in;
    repeat (HOLD_CYCLES) @(posedge sys_clk);
  endtask : bounce
endmodule : trgctl_switch_model

//--- tb/trgctl_top_tb.sv
// self-checking bench for the trigger mode control block
`timescale 1ns/10ps
module trgctl_top_tb;
  import trgctl_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        trig_in;
  logic        local_key;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rd;
  logic        seq_go;
  logic        seq_stop;
  logic        panel_locked;
  logic        local_restore;
  logic        xtrm_track_en;
  logic        xtrm_reload;
  int          err_count;
  int          check_count;
  int          go_cnt;
  int          stop_cnt;
  int          reload_cnt;

  trgctl_top #(.TICK_CYCLES(2), .FILTER_TICKS(3)) dut (
    .sys_clk(sys_clk), .rst(rst), .trig_in(trig_in), .local_key(local_key),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seq_go(seq_go), .seq_stop(seq_stop),
    .panel_locked(panel_locked), .local_restore(local_restore),
    .xtrm_track_en(xtrm_track_en), .xtrm_reload(xtrm_reload));
  trgctl_switch_model #(.HOLD_CYCLES(40)) sw (.sys_clk(sys_clk), .trig_in(trig_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // pulse counters: a pulse standing two cycles counts twice
  always @(posedge sys_clk)
    if (!rst)
    begin
      go_cnt += seq_go;
      stop_cnt += seq_stop;
      reload_cnt += xtrm_reload;
    end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic test_reset();
    check({26'h0, seq_go, seq_stop, panel_locked, local_restore, xtrm_track_en, xtrm_reload},
          32'h0000_0000);
    reg_read(TRGCTL_REG_CTRL, rd);
    check(rd, 32'h0000_0000);
    @(posedge sys_clk);
    #1 check(reg_rdata, 32'h0000_0000);
    reg_read(TRGCTL_REG_STATUS, rd);
    check(rd, 32'h0000_0000);
    reg_write(4'hc, 32'h0000_0013);
    reg_read(4'h8, rd);
    check(rd, 32'h0000_0000);
    reg_read(TRGCTL_REG_CTRL, rd);
    check(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_inactive();
    for (int c = 0; c < 3; c++)
    begin
      reg_write(TRGCTL_REG_CTRL, 32'(c));
      sw.drive(1'b1);
      check(32'(panel_locked), 32'h0000_0000);
      sw.drive(1'b0);
    end
    check(32'(go_cnt + stop_cnt + reload_cnt), 32'h0000_0000);
    $display("test inactive done");
  endtask : test_inactive

  task automatic test_step();
    reg_write(TRGCTL_REG_CTRL, 32'(TRGCTL_FUNC_STEP));
    sw.drive(1'b1);
    check(32'(go_cnt), 32'h0000_0001);
    check(32'(stop_cnt), 32'h0000_0000);
    reg_read(TRGCTL_REG_STATUS, rd);
    check(rd, 32'h0000_0001);
    sw.drive(1'b0);
    check(32'(stop_cnt), 32'h0000_0001);
    sw.bounce();
    check(32'(go_cnt + stop_cnt), 32'h0000_0002);
    sw.drive(1'b1);
    sw.drive(1'b0);
    check(32'(go_cnt + stop_cnt), 32'h0000_0004);
    $display("test step program done");
  endtask : test_step

  task automatic test_lock();
    reg_write(TRGCTL_REG_CTRL, 32'(TRGCTL_FUNC_LOCK));
    @(posedge sys_clk);
    local_key <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({30'h0, panel_locked, local_restore}, 32'h0000_0001);
    sw.drive(1'b1);
    check(32'(panel_locked), 32'h0000_0001);
    check(32'(local_restore), 32'h0000_0000);
    reg_read(TRGCTL_REG_STATUS, rd);
    check(rd, 32'h0000_0003);
    sw.drive(1'b0);
    check({30'h0, panel_locked, local_restore}, 32'h0000_0001);
    @(posedge sys_clk);
    local_key <= 1'b0;
    $display("test lockout done");
  endtask : test_lock

  task automatic test_xtrm();
    reg_write(TRGCTL_REG_CTRL, 32'h0000_0015);
    repeat (3) @(posedge sys_clk);
    check(32'(xtrm_track_en), 32'h0000_0001);
    sw.drive(1'b1);
    check(32'(xtrm_track_en), 32'h0000_0000);
    check(32'(reload_cnt), 32'h0000_0000);
    reg_read(TRGCTL_REG_STATUS, rd);
    check(rd, 32'h0000_0001);
    sw.drive(1'b0);
    check(32'(reload_cnt), 32'h0000_0001);
    check(32'(xtrm_track_en), 32'h0000_0001);
    reg_write(TRGCTL_REG_CTRL, 32'(TRGCTL_FUNC_XTRM));
    repeat (3) @(posedge sys_clk);
    check(32'(xtrm_track_en), 32'h0000_0000);
    sw.drive(1'b1);
    sw.drive(1'b0);
    check(32'(reload_cnt), 32'h0000_0001);
    $display("test extremes recorder done");
  endtask : test_xtrm

  // reset in mid-run with the panel locked and the trigger still high
  task automatic test_midreset();
    reg_write(TRGCTL_REG_CTRL, 32'(TRGCTL_FUNC_LOCK));
    sw.drive(1'b1);
    check(32'(panel_locked), 32'h0000_0001);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 check({26'h0, seq_go, seq_stop, panel_locked, local_restore, xtrm_track_en, xtrm_reload},
             32'h0000_0000);
    reg_read(TRGCTL_REG_CTRL, rd);
    check(rd, 32'h0000_0000);
    sw.drive(1'b0);
    check(32'(panel_locked), 32'h0000_0000);
    $display("test mid-run reset done");
  endtask : test_midreset

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    rst = 1'b1;
    local_key = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_reset();
    test_inactive();
    test_step();
    test_lock();
    test_xtrm();
    test_midreset();
    wrap_up();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule : trgctl_top_tb

//--- verilog/trgctl_filter.sv
// synchroniser, debounce filter and edge detector for the trigger input
`timescale 1ns/10ps
module trgctl_filter
  import trgctl_pkg::*;
#(
  parameter int TICK_CYCLES  = TRGCTL_TICK_CYCLES,
  parameter int FILTER_TICKS = TRGCTL_FILTER_TICKS
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic trig_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  initial
  begin
    if (TICK_CYCLES < 1 || FILTER_TICKS < 1 || TICK_CYCLES > 65535 || FILTER_TICKS > 65535)
      $error("trgctl_filter: counts out of range");
  end

  logic        sync_a;
  logic        sync_b;
  logic [15:0] div_cnt;
  logic [15:0] flt_cnt;
  logic        next_sync_a;
  logic        next_sync_b;
  logic [15:0] next_div_cnt;
  logic [15:0] next_flt_cnt;
  logic        next_level;
  logic        next_rise;
  logic        next_fall;
  logic        tick;

  always_comb
  begin
    next_sync_a  = trig_in;
    next_sync_b  = sync_a;
    tick         = (div_cnt == 16'(TICK_CYCLES - 1));
    next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
    next_flt_cnt = flt_cnt;
    next_level   = level;
    next_rise    = 1'b0;
    next_fall    = 1'b0;
    // level must stay different for the full filter time before it is taken
    if (sync_b == level)                                                  // RULE15
      next_flt_cnt = 16'h0000;
    else if (tick)
    begin
      if (flt_cnt == 16'(FILTER_TICKS - 1))
      begin
        next_flt_cnt = 16'h0000;
        next_level   = sync_b;
        next_rise    = sync_b;                                            // RULE15
        next_fall    = ~sync_b;                                           // RULE15
      end
      else
        next_flt_cnt = flt_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      div_cnt <= 16'h0000;
      flt_cnt <= 16'h0000;
      level   <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end
    else
    begin
      sync_a  <= next_sync_a;
      sync_b  <= next_sync_b;
      div_cnt <= next_div_cnt;
      flt_cnt <= next_flt_cnt;
      level   <= next_level;
      rise    <= next_rise;
      fall    <= next_fall;
    end
  end

  AST_EDGE_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
    rise |=> !rise) else $error("rise longer than one cycle");            // RULE15
  AST_EDGE_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
    rise |-> level && !$past(level)) else $error("rise without level change"); // RULE15

endmodule : trgctl_filter

//--- verilog/trgctl_pkg.sv
// package with trigger function encodings and timing constants
package trgctl_pkg;

  // trigger function selection held in the trigger menu
  localparam logic [2:0] TRGCTL_FUNC_OFF    = 3'h0;
  localparam logic [2:0] TRGCTL_FUNC_OUTPUT = 3'h1;
  localparam logic [2:0] TRGCTL_FUNC_RECALL = 3'h2;
  localparam logic [2:0] TRGCTL_FUNC_STEP   = 3'h3;
  localparam logic [2:0] TRGCTL_FUNC_LOCK   = 3'h4;
  localparam logic [2:0] TRGCTL_FUNC_XTRM   = 3'h5;

  // register offsets of the control port
  localparam logic [3:0] TRGCTL_REG_CTRL   = 4'h0;
  localparam logic [3:0] TRGCTL_REG_STATUS = 4'h4;

  // control register fields
  localparam int TRGCTL_CTRL_FUNC_LSB = 0;
  localparam int TRGCTL_CTRL_FUNC_MSB = 2;
  localparam int TRGCTL_CTRL_XREC_BIT = 4;
  localparam logic [2:0] TRGCTL_FUNC_RESET = 3'h0;

  // status register fields
  localparam int TRGCTL_STAT_LEVEL_BIT = 0;
  localparam int TRGCTL_STAT_LOCK_BIT  = 1;
  localparam int TRGCTL_STAT_TRACK_BIT = 2;

  // timing
  localparam int TRGCTL_CLK_MHZ      = 250;
  localparam int TRGCTL_TICK_US      = 1;
  localparam int TRGCTL_TICK_CYCLES  = TRGCTL_CLK_MHZ * TRGCTL_TICK_US;
  localparam int TRGCTL_FILTER_US    = 1000;
  localparam int TRGCTL_FILTER_TICKS = TRGCTL_FILTER_US / TRGCTL_TICK_US;

endpackage : trgctl_pkg

//--- verilog/trgctl_top.sv
// trigger input handling for step program, panel lockout and extremes recorder modes
// Functional notes
// RULE1 - step program mode: rising trigger starts program at its start address
// RULE2 - step program mode: falling trigger jumps execution to the stop address
// RULE3 - lockout mode: low trigger leaves all panel controls working
// RULE4 - lockout mode: high trigger ignores all panel controls except mains switch
// RULE5 - while lockout held, local-return key cannot re-enable the panel
// RULE6 - extremes mode governs storage only while extremes recorder is switched on
// RULE7 - extremes mode: low trigger keeps min and max tracking active
// RULE8 - extremes mode: rising trigger stops tracking, stored extremes kept
// RULE9 - extremes mode: high trigger suspends tracking, no extreme updated
// RULE10 - extremes mode: falling trigger loads extremes with present readings, resumes tracking
// RULE11 - trigger function selection setting chooses the action taken
// RULE12 - function off: all trigger levels and transitions are ignored
// RULE13 - external driver holds each trigger level at least 14 ms
// RULE14 - controlled function responds 1 to 15 ms after the signal change
// RULE15 - input synchronised, filtered, and single-cycle edges derived
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module trgctl_top
  import trgctl_pkg::*;
#(
  parameter int TICK_CYCLES  = TRGCTL_TICK_CYCLES,
  parameter int FILTER_TICKS = TRGCTL_FILTER_TICKS
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        trig_in,
  input  wire logic        local_key,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             seq_go,
  output logic             seq_stop,
  output logic             panel_locked,
  output logic             local_restore,
  output logic             xtrm_track_en,
  output logic             xtrm_reload
);

  typedef enum {TRGCTL_XT_TRACK, TRGCTL_XT_HOLD} trgctl_xt_type;

  function automatic logic trgctl_sel(input logic [2:0] func, input logic [2:0] want);
    trgctl_sel = (func == want);
  endfunction : trgctl_sel

  // the filter counters are sixteen bits wide
  initial
  begin
    if (TICK_CYCLES < 1 || FILTER_TICKS < 1 || TICK_CYCLES > 65535 || FILTER_TICKS > 65535)
      $error("trgctl_top: counts out of range");
  end

  logic          level;
  logic          rise;
  logic          fall;
  logic [2:0]    func_sel;
  logic          xrec_on;
  trgctl_xt_type xt_state;
  logic [2:0]    next_func_sel;
  logic          next_xrec_on;
  trgctl_xt_type next_xt_state;
  logic [31:0]   next_reg_rdata;
  logic          next_seq_go;
  logic          next_seq_stop;
  logic          next_panel_locked;
  logic          next_local_restore;
  logic          next_xtrm_track_en;
  logic          next_xtrm_reload;
  logic          mode_step;
  logic          mode_lock;
  logic          mode_xtrm;

  trgctl_filter #(
    .TICK_CYCLES  (TICK_CYCLES),
    .FILTER_TICKS (FILTER_TICKS)
  ) u_filter (
    .sys_clk (sys_clk),
    .rst     (rst),
    .trig_in (trig_in),
    .level   (level),
    .rise    (rise),
    .fall    (fall)
  );

  // register port
  always_comb
  begin
    next_func_sel  = func_sel;
    next_xrec_on   = xrec_on;
    next_reg_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == TRGCTL_REG_CTRL)
    begin
      next_func_sel = reg_wdata[TRGCTL_CTRL_FUNC_MSB:TRGCTL_CTRL_FUNC_LSB];        // RULE11
      next_xrec_on  = reg_wdata[TRGCTL_CTRL_XREC_BIT];
    end
    if (reg_rd)
    begin
      if (reg_addr == TRGCTL_REG_CTRL)
      begin
        next_reg_rdata[TRGCTL_CTRL_FUNC_MSB:TRGCTL_CTRL_FUNC_LSB] = func_sel;
        next_reg_rdata[TRGCTL_CTRL_XREC_BIT] = xrec_on;
      end
      else if (reg_addr == TRGCTL_REG_STATUS)
      begin
        next_reg_rdata[TRGCTL_STAT_LEVEL_BIT] = level;
        next_reg_rdata[TRGCTL_STAT_LOCK_BIT]  = panel_locked;
        next_reg_rdata[TRGCTL_STAT_TRACK_BIT] = xtrm_track_en;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      func_sel  <= TRGCTL_FUNC_RESET;
      xrec_on   <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      func_sel  <= next_func_sel;
      xrec_on   <= next_xrec_on;
      reg_rdata <= next_reg_rdata;
    end
  end

  // mode decode; off and the other functions take no action here
  assign mode_step = trgctl_sel(func_sel, TRGCTL_FUNC_STEP);                  // RULE11 RULE12
  assign mode_lock = trgctl_sel(func_sel, TRGCTL_FUNC_LOCK);                  // RULE12
  assign mode_xtrm = trgctl_sel(func_sel, TRGCTL_FUNC_XTRM) && xrec_on;       // RULE6 RULE12

  // trigger actions
  always_comb
  begin
    next_xt_state      = xt_state;
    next_seq_go        = mode_step && rise;                                   // RULE1
    next_seq_stop      = mode_step && fall;                                   // RULE2
    next_panel_locked  = mode_lock && level;                                  // RULE3 RULE4
    // local key only restores the panel when no lockout is held
    next_local_restore = local_key && !(mode_lock && level);                  // RULE5
    next_xtrm_reload   = 1'b0;
    if (!mode_xtrm)
      next_xt_state = TRGCTL_XT_TRACK;
    else
    begin
      case (xt_state)
        TRGCTL_XT_TRACK:
        begin
          if (rise || level)
            next_xt_state = TRGCTL_XT_HOLD;                                   // RULE8
        end
        TRGCTL_XT_HOLD:
        begin
          if (fall || !level)
          begin
            next_xt_state    = TRGCTL_XT_TRACK;                               // RULE10
            next_xtrm_reload = 1'b1;                                          // RULE10
          end
        end
        default:
          next_xt_state = TRGCTL_XT_TRACK;
      endcase
    end
    // track when low, suspend while held high
    next_xtrm_track_en = xrec_on && (next_xt_state == TRGCTL_XT_TRACK);       // RULE7 RULE9
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      xt_state      <= TRGCTL_XT_TRACK;
      seq_go        <= 1'b0;
      seq_stop      <= 1'b0;
      panel_locked  <= 1'b0;
      local_restore <= 1'b0;
      xtrm_track_en <= 1'b0;
      xtrm_reload   <= 1'b0;
    end
    else
    begin
      xt_state      <= next_xt_state;
      seq_go        <= next_seq_go;
      seq_stop      <= next_seq_stop;
      panel_locked  <= next_panel_locked;
      local_restore <= next_local_restore;
      xtrm_track_en <= next_xtrm_track_en;
      xtrm_reload   <= next_xtrm_reload;
    end
  end

  sequence trgctl_rise_in_step;
    rise && mode_step;
  endsequence

  sequence trgctl_go_pulse;
    seq_go ##1 !seq_go;
  endsequence

  AST_SEQ_GO: assert property (@(posedge sys_clk) disable iff (rst)
    trgctl_rise_in_step |=> trgctl_go_pulse) else $error("no start on rise"); // RULE1
  AST_SEQ_STOP: assert property (@(posedge sys_clk) disable iff (rst)
    fall && mode_step |=> seq_stop && !seq_go) else $error("no stop on fall"); // RULE2
  AST_PANEL_FREE: assert property (@(posedge sys_clk) disable iff (rst)
    mode_lock && !level |=> !panel_locked) else $error("panel locked at low"); // RULE3
  AST_PANEL_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
    mode_lock && level |=> panel_locked) else $error("panel not locked at high"); // RULE4
  AST_LOCAL_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    panel_locked |-> !local_restore) else $error("local key unlocked panel"); // RULE5
  AST_OFF_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
    func_sel == TRGCTL_FUNC_OFF && $past(func_sel) == TRGCTL_FUNC_OFF
    |-> !seq_go && !seq_stop && !panel_locked && !xtrm_reload)
    else $error("trigger acted while off");                                  // RULE12
  AST_XTRM_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !xrec_on |=> !xtrm_reload && !xtrm_track_en) else $error("recorder off but active"); // RULE6
  AST_XTRM_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    mode_xtrm && level && $past(level) |=> !xtrm_track_en && !xtrm_reload)
    else $error("tracking while high");                                      // RULE9
  AST_XTRM_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    mode_xtrm && rise |=> !xtrm_track_en && !xtrm_reload) else $error("rise kept tracking"); // RULE8
  AST_XTRM_FALL: assert property (@(posedge sys_clk) disable iff (rst)
    mode_xtrm && fall && xt_state == TRGCTL_XT_HOLD |=> xtrm_reload && xtrm_track_en ##1 !xtrm_reload)
    else $error("no reload on fall");                                        // RULE10
  AST_XTRM_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    mode_xtrm && !level && $past(!level) && $past(mode_xtrm) |=> xtrm_track_en)
    else $error("not tracking at low");                                      // RULE7

  // latency watch: cycles from the last raw input change to an action pulse
  localparam int LAT_MIN = (FILTER_TICKS - 1) * TICK_CYCLES;
  // two synchroniser stages, one tick of phase and the output register
  localparam int LAT_MAX = (FILTER_TICKS + 1) * TICK_CYCLES + 3;

  logic        trig_prev;
  logic        next_trig_prev;
  logic [31:0] since_chg;
  logic [31:0] next_since_chg;

  // saturates so that a long quiet input never wraps to a short latency
  always_comb
  begin
    next_trig_prev = trig_in;
    if (trig_in != trig_prev)
      next_since_chg = 32'h0000_0000;
    else if (since_chg != 32'hFFFF_FFFF)
      next_since_chg = since_chg + 32'h0000_0001;
    else
      next_since_chg = since_chg;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      trig_prev <= 1'b0;
      since_chg <= 32'hFFFF_FFFF;
    end
    else
    begin
      trig_prev <= next_trig_prev;
      since_chg <= next_since_chg;
    end
  end

  sequence trgctl_action_pulse;
    seq_go || seq_stop || xtrm_reload;
  endsequence

  sequence trgctl_reload_pulse;
    xtrm_reload ##1 !xtrm_reload;
  endsequence

  AST_LATENCY: assert property (@(posedge sys_clk) disable iff (rst)            // RULE14
    trgctl_action_pulse |-> since_chg >= LAT_MIN && since_chg <= LAT_MAX)
    else $error("action outside trigger latency");
  AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (rst)         // RULE11
    reg_wr && reg_addr == TRGCTL_REG_CTRL
    |=> func_sel == $past(reg_wdata[TRGCTL_CTRL_FUNC_MSB:TRGCTL_CTRL_FUNC_LSB]))
    else $error("function selection not taken");
  AST_STEP_QUIET: assert property (@(posedge sys_clk) disable iff (rst)         // RULE11
    !mode_step |=> !seq_go && !seq_stop) else $error("step action outside step mode");
  AST_PANEL_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)      // RULE3
    mode_lock && fall |=> !panel_locked) else $error("panel kept locked after fall");
  AST_LOCK_QUIET: assert property (@(posedge sys_clk) disable iff (rst)         // RULE11
    !mode_lock |=> !panel_locked) else $error("panel locked outside lockout mode");
  AST_XTRM_RELOAD_ONE: assert property (@(posedge sys_clk) disable iff (rst)    // RULE10
    mode_xtrm && fall && xt_state == TRGCTL_XT_HOLD |=> trgctl_reload_pulse)
    else $error("reload pulse not one cycle");
  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");
  AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (rst)        // RULE4
    reg_rd && reg_addr == TRGCTL_REG_STATUS
    |=> reg_rdata[TRGCTL_STAT_LOCK_BIT] == $past(panel_locked))
    else $error("status shows wrong lock state");

endmodule : trgctl_top
